// file: shared/pbr_pkg.sv
// constants for the serial-bus phy base register bank
package pbr_pkg;
	// register indices on the phy register port
	localparam logic [3:0] ADDR_IDENTITY   = 4'h0;
	localparam logic [3:0] ADDR_RESET_GAP  = 4'h1;
	localparam logic [3:0] ADDR_CAPABILITY = 4'h2;
	localparam logic [3:0] ADDR_SPEED_STBY = 4'h3;
	// node_identity_status fields
	localparam int NODE_MSB = 7;
	localparam int NODE_LSB = 2;
	localparam int ROOT_BIT = 1;
	localparam int CPS_BIT  = 0;
	// reset_and_gap_control fields
	localparam int HOLDOFF_BIT = 7;
	localparam int LONGRST_BIT = 6;
	localparam int GAP_MSB     = 5;
	localparam int GAP_LSB     = 0;
	// capability_port_count fields
	localparam int EXT_MSB   = 7;
	localparam int EXT_LSB   = 5;
	localparam int PORTS_MSB = 3;
	localparam int PORTS_LSB = 0;
	// speed_and_standby fields
	localparam int SPEED_MSB   = 7;
	localparam int SPEED_LSB   = 5;
	localparam int STANDBY_BIT = 4;
	localparam int DELAY_MSB   = 3;
	localparam int DELAY_LSB   = 0;
	// fixed values and reset values
	localparam logic [5:0] GAP_RESET   = 6'h3F;
	localparam logic [2:0] EXT_CODE    = 3'h7;
	localparam logic [3:0] PORT_COUNT  = 4'h3;
	localparam logic [2:0] SPEED_CODE  = 3'h7;
	localparam logic [3:0] DELAY_CODE  = 4'hF;
	localparam logic [7:0] READ_ZERO   = 8'h00;
	// long bus reset timing
	localparam int CLK_KHZ          = 10000;
	localparam int LONG_RESET_US    = 166;
	localparam int LONG_RESET_CYCLES = (LONG_RESET_US * CLK_KHZ) / 1000;
endpackage

// file: design/pbr_long_reset.sv
// timer that drives a long bus reset for a fixed number of cycles
`timescale 1ns/1ps
`default_nettype none
module pbr_long_reset #(
	parameter int CYCLES = 1660
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// control
	input  wire logic start,
	output var  logic active
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count_reg;

	initial begin
		if (CYCLES < 2)
			$error("pbr_long_reset: CYCLES must be at least 2");
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			active    <= 1'b0;
			count_reg <= '0;
		end else if (start && !active) begin
			active    <= 1'b1;
			count_reg <= '0;
		end else if (active) begin
			if (count_reg == LAST)
				active <= 1'b0;
			count_reg <= count_reg + 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: design/pbr_base_regs.sv
// base register bank of a three-port serial-bus cable phy
`timescale 1ns/1ps
`default_nettype none
module pbr_base_regs
	import pbr_pkg::*;
#(
	parameter int NUM_PORTS    = 3,
	parameter int RESET_CYCLES = LONG_RESET_CYCLES
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// register port from the link layer controller
	input  wire logic [3:0]           regAddr,
	input  wire logic                 regWrEn,
	input  wire logic [7:0]           regWrData,
	input  wire logic                 regRdEn,
	output var  logic [7:0]           regRdData,
	output var  logic                 regRdValid,
	// unsolicited status transfer
	output var  logic                 statusValid,
	output var  logic [7:0]           statusData,
	// bus events from the arbiter
	input  wire logic                 busResetIn,
	input  wire logic                 treeRoot,
	input  wire logic                 selfIdDone,
	input  wire logic [5:0]           selfIdNodeNumber,
	input  wire logic                 linkBusy,
	input  wire logic                 cablePowerSense,
	// phy configuration packets seen or sent
	input  wire logic                 cfgValid,
	input  wire logic                 cfgHoldoff,
	input  wire logic                 cfgGapValid,
	input  wire logic [5:0]           cfgGap,
	// standby commands
	input  wire logic                 standbyCmd,
	input  wire logic                 restoreCmd,
	input  wire logic [1:0]           cmdPort,
	output var  logic [NUM_PORTS-1:0] portStandby,
	// settings toward the arbiter
	output var  logic [5:0]           nodeNumber,
	output var  logic                 nodeNumberValid,
	output var  logic                 rootFlag,
	output var  logic                 rootHoldoff,
	output var  logic [5:0]           gapCount,
	output var  logic                 longResetActive
);
	logic       longResetReq_reg;
	logic       gapUntouched_reg;
	logic       standbyPermit_reg;
	logic       resetStart;
	logic       wrReg1;
	logic       wrReg3;
	logic [7:0] readMux;

	initial begin
		if (NUM_PORTS < 1 || NUM_PORTS > 4)
			$error("pbr_base_regs: NUM_PORTS must be 1 to 4");
	end

	assign wrReg1 = regWrEn && (regAddr == ADDR_RESET_GAP);
	assign wrReg3 = regWrEn && (regAddr == ADDR_SPEED_STBY);

	// node number and its validity; completion wins over a reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nodeNumber      <= '0;
			nodeNumberValid <= 1'b0;
		end else if (selfIdDone) begin
			nodeNumber      <= selfIdNodeNumber;
			nodeNumberValid <= 1'b1;
		end else if (busResetIn) begin
			nodeNumberValid <= 1'b0;
		end
	end

	// status transfer carries the fresh register 0 contents
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			statusValid <= 1'b0;
			statusData  <= '0;
		end else begin
			statusValid <= selfIdDone;
			if (selfIdDone)
				statusData <= {selfIdNodeNumber, rootFlag || treeRoot,
					cablePowerSense};
		end
	end

	// root flag: tree identification sets, bus reset clears, set wins
	always_ff @(posedge clk) begin
		if (!rst_n)
			rootFlag <= 1'b0;
		else if (treeRoot)
			rootFlag <= 1'b1;
		else if (busResetIn)
			rootFlag <= 1'b0;
	end

	// root holdoff survives bus resets; config packets are the safe path
	always_ff @(posedge clk) begin
		if (!rst_n)
			rootHoldoff <= 1'b0;
		else if (cfgValid)
			rootHoldoff <= cfgHoldoff;
		else if (wrReg1)
			rootHoldoff <= regWrData[HOLDOFF_BIT];
	end

	// long reset request; the reset it causes counts as a bus reset
	always_ff @(posedge clk) begin
		if (!rst_n)
			longResetReq_reg <= 1'b0;
		else if (wrReg1)
			longResetReq_reg <= regWrData[LONGRST_BIT];
		else if (busResetIn || resetStart)
			longResetReq_reg <= 1'b0;
	end

	// wait for traffic in flight to drain before resetting the bus
	assign resetStart = longResetReq_reg && !linkBusy
		&& !longResetActive;

	pbr_long_reset #(
		.CYCLES (RESET_CYCLES)
	) longReset (
		.clk    (clk),
		.rst_n  (rst_n),
		.start  (resetStart),
		.active (longResetActive)
	);

	// gap: second bus reset with no write in between restores default
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gapCount         <= GAP_RESET;
			gapUntouched_reg <= 1'b0;
		end else if (cfgValid && cfgGapValid) begin
			gapCount         <= cfgGap;
			gapUntouched_reg <= 1'b0;
		end else if (wrReg1) begin
			gapCount         <= regWrData[GAP_MSB:GAP_LSB];
			gapUntouched_reg <= 1'b0;
		end else if (busResetIn) begin
			if (gapUntouched_reg)
				gapCount <= GAP_RESET;
			gapUntouched_reg <= 1'b1;
		end
	end

	// standby permit is the only writable bit of register 3
	always_ff @(posedge clk) begin
		if (!rst_n)
			standbyPermit_reg <= 1'b0;
		else if (wrReg3)
			standbyPermit_reg <= regWrData[STANDBY_BIT];
	end

	// per-port standby; a bus reset or restore wakes the port
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : gPort
			always_ff @(posedge clk) begin
				if (!rst_n)
					portStandby[p] <= 1'b0;
				else if (standbyCmd && standbyPermit_reg
					&& cmdPort == 2'(p))
					portStandby[p] <= 1'b1;
				else if (busResetIn || (restoreCmd && cmdPort == 2'(p)))
					portStandby[p] <= 1'b0;
			end
		end
	endgenerate

	// read path; unlisted addresses and spare bits read zero
	always_comb begin
		readMux = READ_ZERO;
		case (regAddr)
			ADDR_IDENTITY: begin
				readMux[NODE_MSB:NODE_LSB] = nodeNumber;
				readMux[ROOT_BIT]          = rootFlag;
				readMux[CPS_BIT]           = cablePowerSense;
			end
			ADDR_RESET_GAP: begin
				readMux[HOLDOFF_BIT]     = rootHoldoff;
				readMux[LONGRST_BIT]     = longResetReq_reg;
				readMux[GAP_MSB:GAP_LSB] = gapCount;
			end
			ADDR_CAPABILITY: begin
				readMux[EXT_MSB:EXT_LSB]     = EXT_CODE;
				readMux[PORTS_MSB:PORTS_LSB] = PORT_COUNT;
			end
			ADDR_SPEED_STBY: begin
				readMux[SPEED_MSB:SPEED_LSB] = SPEED_CODE;
				readMux[STANDBY_BIT]         = standbyPermit_reg;
				readMux[DELAY_MSB:DELAY_LSB] = DELAY_CODE;
			end
			default: readMux = READ_ZERO;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regRdData  <= '0;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			if (regRdEn)
				regRdData <= readMux;
		end
	end

	// checks
	sequence sResetRun;
		longResetActive [*8];
	endsequence

	sequence sTwoResets;
		busResetIn && !cfgValid && !regWrEn ##1
			(!cfgValid && !regWrEn && !busResetIn) [*1] ##1
			busResetIn && !cfgValid && !regWrEn;
	endsequence

	node_invalid_a: assert property (@(posedge clk) disable iff (!rst_n)
		busResetIn && !selfIdDone |=> !nodeNumberValid)
		else $error("node number valid after bus reset");

	status_xfer_a: assert property (@(posedge clk) disable iff (!rst_n)
		selfIdDone |=> statusValid
			&& statusData[NODE_MSB:NODE_LSB] == $past(selfIdNodeNumber))
		else $error("status transfer missing or wrong");

	root_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		busResetIn && !treeRoot |=> !rootFlag)
		else $error("root flag survived bus reset");

	cps_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		regRdEn && regAddr == ADDR_IDENTITY
			|=> regRdData[CPS_BIT] == $past(cablePowerSense))
		else $error("cable power bit wrong");

	holdoff_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		busResetIn && !cfgValid && !regWrEn |=> $stable(rootHoldoff))
		else $error("root holdoff changed by bus reset");

	long_run_a: assert property (@(posedge clk) disable iff (!rst_n)
		resetStart |=> sResetRun)
		else $error("long reset too short");

	drain_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(longResetActive) |-> !$past(linkBusy))
		else $error("bus reset began during traffic");

	req_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		busResetIn && !regWrEn |=> !longResetReq_reg)
		else $error("long reset request not cleared");

	gap_restore_a: assert property (@(posedge clk) disable iff (!rst_n)
		sTwoResets |=> gapCount == GAP_RESET)
		else $error("gap not restored after two resets");

	const_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		regRdEn && regAddr == ADDR_CAPABILITY
			|=> regRdData == {EXT_CODE, 1'b0, PORT_COUNT})
		else $error("capability register wrong");

	ro_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		regWrEn && regAddr == ADDR_IDENTITY && !selfIdDone
			&& !busResetIn && !treeRoot
			|=> $stable(nodeNumber) && $stable(rootFlag))
		else $error("read-only field changed by write");
endmodule
`default_nettype wire

// file: verification/pbr_link_model.sv
// link-side model that drives the phy register port
`timescale 1ns/1ps
`default_nettype none
module pbr_link_model (
	// clock
	input  wire logic       clk,
	// register port toward the phy
	output var  logic [3:0] regAddr,
	output var  logic       regWrEn,
	output var  logic [7:0] regWrData,
	output var  logic       regRdEn
);
	initial begin
		regAddr = 4'h0;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end
	// callers pass whole bytes that keep holdoff and gap
	// holdoff and gap mostly come by config packet
	// no short reset and no standby of non-leaves asked
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: verification/pbr_base_regs_test.sv
// self-checking bench for the phy base register bank
`timescale 1ns/1ps
`default_nettype none
module pbr_base_regs_test;
	import pbr_pkg::*;
	localparam int RC = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] regAddr;
	logic regWrEn, regRdEn, regRdValid, statusValid;
	logic [7:0] regWrData, regRdData, statusData;
	logic busResetIn, treeRoot, selfIdDone, linkBusy, cablePowerSense;
	logic cfgValid, cfgHoldoff, cfgGapValid, standbyCmd, restoreCmd;
	logic [5:0] selfIdNodeNumber, cfgGap, nodeNumber, gapCount;
	logic [1:0] cmdPort;
	logic [2:0] portStandby;
	logic nodeNumberValid, rootFlag, rootHoldoff, longResetActive;
	logic [7:0] rdQ[$];
	logic [7:0] stQ[$];
	int num_errors = 0;
	int checks = 0;
	int seed, k, n;
	logic [5:0] id;
	logic cable_power_sense;
	logic [1:0] p;
	always #50 clk = ~clk;
	pbr_link_model lnk (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn));
	pbr_base_regs #(.NUM_PORTS(3), .RESET_CYCLES(RC)) dut (
		.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .statusValid(statusValid),
		.statusData(statusData), .busResetIn(busResetIn),
		.treeRoot(treeRoot), .selfIdDone(selfIdDone),
		.selfIdNodeNumber(selfIdNodeNumber), .linkBusy(linkBusy),
		.cablePowerSense(cablePowerSense), .cfgValid(cfgValid),
		.cfgHoldoff(cfgHoldoff), .cfgGapValid(cfgGapValid),
		.cfgGap(cfgGap), .standbyCmd(standbyCmd),
		.restoreCmd(restoreCmd),
		.cmdPort(cmdPort), .portStandby(portStandby),
		.nodeNumber(nodeNumber), .nodeNumberValid(nodeNumberValid),
		.rootFlag(rootFlag), .rootHoldoff(rootHoldoff),
		.gapCount(gapCount), .longResetActive(longResetActive));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one-cycle pulse of {busReset, treeRoot, selfIdDone, cfg, standby}
	task automatic ev(input logic [4:0] m);
		@(posedge clk);
		{busResetIn, treeRoot, selfIdDone, cfgValid, standbyCmd} <= m;
		@(posedge clk);
		{busResetIn, treeRoot, selfIdDone, cfgValid, standbyCmd} <= 5'h00;
	endtask
	task automatic rx(input logic [3:0] a, input logic [7:0] e);
		rdQ.push_back(e);
		lnk.rd(a);
	endtask
	// a result with no note left is forced to mismatch
	always @(posedge clk) begin
		if (regRdValid === 1'b1)
			chk(regRdData, rdQ.size() ? rdQ.pop_front() : ~regRdData);
		if (statusValid === 1'b1)
			chk(statusData, stQ.size() ? stQ.pop_front() : ~statusData);
	end
	initial begin
		#(100 * 5000);
		num_errors++;
		final_report();
	end
	initial begin
		seed = 43;
		{busResetIn, treeRoot, selfIdDone, cfgValid, standbyCmd} = 5'h00;
		{linkBusy, cfgHoldoff, cfgGapValid} = 3'h0;
		restoreCmd = 1'b0;
		cablePowerSense = 1'b1;
		selfIdNodeNumber = 6'h00;
		cfgGap = 6'h00;
		cmdPort = 2'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rx(ADDR_IDENTITY, 8'h01);
		rx(ADDR_RESET_GAP, 8'h3F);
		rx(ADDR_CAPABILITY, 8'hE3);
		rx(ADDR_SPEED_STBY, 8'hEF);
		for (int a = 4; a < 16; a++)
			rx(4'(a), 8'h00);
		lnk.wr(ADDR_IDENTITY, 8'hFE);
		lnk.wr(ADDR_CAPABILITY, 8'h1C);
		rx(ADDR_IDENTITY, 8'h01);
		rx(ADDR_CAPABILITY, 8'hE3);
		$display("test reset values done");
		id = 6'($random(seed));
		cable_power_sense = 1'($random(seed));
		cablePowerSense <= cable_power_sense;
		ev(5'h08);
		stQ.push_back({id, 1'b1, cable_power_sense});
		selfIdNodeNumber <= id;
		ev(5'h04);
		rx(ADDR_IDENTITY, {id, 1'b1, cable_power_sense});
		chk({7'h00, nodeNumberValid}, 8'h01);
		ev(5'h10);
		@(negedge clk);
		chk({6'h00, rootFlag, nodeNumberValid}, 8'h00);
		$display("test self id done");
		lnk.wr(ADDR_RESET_GAP, 8'h05);
		rx(ADDR_RESET_GAP, 8'h05);
		{cfgHoldoff, cfgGapValid, cfgGap} <= {2'h3, 6'h12};
		ev(5'h02);
		rx(ADDR_RESET_GAP, 8'h92);
		ev(5'h10);
		rx(ADDR_RESET_GAP, 8'h92);
		ev(5'h10);
		rx(ADDR_RESET_GAP, 8'hBF);
		// two resets with one idle cycle between, right after a config gap write
		ev(5'h02);
		ev(5'h10);
		ev(5'h10);
		rx(ADDR_RESET_GAP, 8'hBF);
		$display("test gap done");
		linkBusy <= 1'b1;
		lnk.wr(ADDR_RESET_GAP, 8'hFF);
		repeat (5) @(posedge clk);
		chk({7'h00, longResetActive}, 8'h00);
		rx(ADDR_RESET_GAP, 8'hFF);
		linkBusy <= 1'b0;
		k = 0;
		n = 0;
		while (longResetActive !== 1'b1 && k < 10) begin
			@(negedge clk);
			k++;
		end
		while (longResetActive === 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n), 8'(RC));
		rx(ADDR_RESET_GAP, 8'hBF);
		linkBusy <= 1'b1;
		lnk.wr(ADDR_RESET_GAP, 8'hFF);
		ev(5'h10);
		linkBusy <= 1'b0;
		rx(ADDR_RESET_GAP, 8'hBF);
		chk({7'h00, longResetActive}, 8'h00);
		$display("test long reset done");
		cmdPort <= 2'h1;
		ev(5'h01);
		@(negedge clk);
		chk({5'h00, portStandby}, 8'h00);
		lnk.wr(ADDR_SPEED_STBY, 8'h10);
		rx(ADDR_SPEED_STBY, 8'hFF);
		p = 2'($unsigned($random(seed)) % 3);
		cmdPort <= p;
		ev(5'h01);
		@(negedge clk);
		chk({5'h00, portStandby}, 8'(1 << p));
		@(posedge clk);
		restoreCmd <= 1'b1;
		@(posedge clk);
		restoreCmd <= 1'b0;
		@(negedge clk);
		chk({5'h00, portStandby}, 8'h00);
		ev(5'h01);
		@(negedge clk);
		chk({5'h00, portStandby}, 8'(1 << p));
		ev(5'h10);
		@(negedge clk);
		chk({5'h00, portStandby}, 8'h00);
		$display("test standby done");
		repeat (3) @(posedge clk);
		chk(8'(rdQ.size() + stQ.size()), 8'h00);
		final_report();
	end
endmodule
`default_nettype wire
